/* File: design/csr_bank.sv */
// core system register bank behind a classic wishbone slave
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module csr_bank (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [3:0]  alu_flag_upd_i,
	input  wire logic [3:0]  alu_flag_val_i,
	input  wire logic [7:0]  irq_event_i,
	input  wire logic        fast_internal_oscillator_i,
	input  wire logic        slow_internal_oscillator_i,
	input  wire logic        external_crystal_oscillator_i,
	input  wire logic        port_a_pin_four_i,
	input  wire logic        port_a_pin_zero_i,
	output logic      [7:0]  stack_pointer_o,
	output logic      [1:0]  sys_clk_src_o,
	output logic      [6:0]  sys_clk_div_o,
	output logic             sys_clk_rsvd_o,
	output logic             fast_osc_en_o,
	output logic             slow_osc_en_o,
	output logic             watchdog_en_o,
	output logic             external_reset_input_en_o,
	output logic      [15:0] timer_count_o,
	output logic             irq_o
);

	// register storage
	logic [3:0]  flag_low;                    // live flag bits
	logic [7:0]  stack_pointer;               // stack pointer
	logic [7:0]  clock_mode_control;          // clock mode
	logic [7:0]  interrupt_enable_mask;       // enables
	logic [7:0]  interrupt_request_flags;     // sticky requests
	logic [7:0]  wide_timer_mode;             // timer mode
	logic [15:0] timer_count;                 // timer counter
	logic [5:0]  prescale;                    // timer prescaler
	// bus decode
	logic        bus_req;                     // request pending
	logic        wr_en;                       // write at ack edge
	logic [5:0]  idx;                         // register index
	logic        aligned;                     // low address bits zero
	logic [7:0]  wdat;                        // low byte written
	logic [7:0]  next_rdat;                   // read mux
	// sync and edge detection for foreign inputs
	logic [4:0]  sync_a;                      // first stage only
	logic [4:0]  sync_b;                      // second stage
	logic [4:0]  sync_c;                      // delayed copy for edges
	logic        fast_rise;
	logic        slow_rise;
	logic        ext_rise;
	logic        pa4_fall;
	logic        pa0_fall;
	// timer datapath
	logic        src_tick;                    // selected clock tick
	logic [5:0]  pre_mask;                    // prescaler mask
	logic        div_tick;                    // divided tick
	logic [15:0] next_count;                  // incremented count
	logic [3:0]  bit_sel;                     // chosen bit index
	logic        t16_event;                   // chosen bit changed
	logic [7:0]  hw_set;                      // all request sets
	logic [9:0]  ck_dec;                      // clock decode

	// system clock decode: {reserved, source, divider}
	function automatic logic [9:0] clk_decode(input logic typ,
		input logic [2:0] sel);
		logic [9:0] r;
		r = {1'b1, csr_pkg::SRC_SLOW, 7'h01};
		if (!typ) begin
			case (sel)
				3'h0:    r = {1'b0, csr_pkg::SRC_FAST, 7'h04};
				3'h1:    r = {1'b0, csr_pkg::SRC_FAST, 7'h02};
				3'h3:    r = {1'b0, csr_pkg::SRC_EXT, 7'h04};
				3'h4:    r = {1'b0, csr_pkg::SRC_EXT, 7'h02};
				3'h5:    r = {1'b0, csr_pkg::SRC_EXT, 7'h01};
				3'h6:    r = {1'b0, csr_pkg::SRC_SLOW, 7'h04};
				3'h7:    r = {1'b0, csr_pkg::SRC_SLOW, 7'h01};
				default: r = {1'b1, csr_pkg::SRC_SLOW, 7'h01};
			endcase
		end else begin
			case (sel)
				3'h0:    r = {1'b0, csr_pkg::SRC_FAST, 7'h10};
				3'h1:    r = {1'b0, csr_pkg::SRC_FAST, 7'h08};
				3'h2:    r = {1'b0, csr_pkg::SRC_SLOW, 7'h10};
				3'h3:    r = {1'b0, csr_pkg::SRC_FAST, 7'h20};
				3'h4:    r = {1'b0, csr_pkg::SRC_FAST, 7'h40};
				3'h5:    r = {1'b0, csr_pkg::SRC_EXT, 7'h08};
				default: r = {1'b1, csr_pkg::SRC_SLOW, 7'h01};
			endcase
		end
		return r;
	endfunction

	// bus decode; writes land on the edge that carries ack
	assign bus_req = wb_cyc_i & wb_stb_i;
	assign idx     = wb_adr_i[7:2];
	assign aligned = (wb_adr_i[1:0] == 2'h0);
	assign wr_en   = bus_req & wb_ack_o & wb_we_i & wb_sel_i[0] & aligned;
	assign wdat    = wb_dat_i[7:0];

	// one-cycle ack, dropped the cycle after it is given
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req & ~wb_ack_o;
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		next_rdat = 8'h00;
		if (aligned) begin
			case (idx)
				csr_pkg::IDX_FLAG:  next_rdat = {csr_pkg::FLAG_ONES, flag_low};
				csr_pkg::IDX_SP:    next_rdat = stack_pointer;
				csr_pkg::IDX_CLKMD: next_rdat = clock_mode_control;
				csr_pkg::IDX_INTEN: next_rdat = interrupt_enable_mask;
				csr_pkg::IDX_INTRQ: next_rdat = interrupt_request_flags;
				csr_pkg::IDX_WIDE_TIMER_MODE:  next_rdat = wide_timer_mode;
				default:            next_rdat = 8'h00;
			endcase
		end
	end

	// read data captured with the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req & ~wb_ack_o) begin
			wb_dat_o <= {24'h00_0000, next_rdat};
		end
	end

	// status flags; alu update wins over a same-cycle software write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_low <= csr_pkg::RST_FLAG[3:0];
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (alu_flag_upd_i[i]) begin
					flag_low[i] <= alu_flag_val_i[i];
				end else if (wr_en && idx == csr_pkg::IDX_FLAG) begin
					flag_low[i] <= wdat[i];
				end
			end
		end
	end

	// stack pointer, plain storage; bit 0 kept by software
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stack_pointer <= csr_pkg::RST_SP;
		end else if (wr_en && idx == csr_pkg::IDX_SP) begin
			stack_pointer <= wdat;
		end
	end

	// clock mode and timer mode storage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clock_mode_control <= csr_pkg::RST_CLKMD;
			wide_timer_mode    <= csr_pkg::RST_WIDE_TIMER_MODE;
		end else if (wr_en) begin
			if (idx == csr_pkg::IDX_CLKMD) begin
				clock_mode_control <= wdat;
			end
			if (idx == csr_pkg::IDX_WIDE_TIMER_MODE) begin
				wide_timer_mode <= wdat;
			end
		end
	end

	// interrupt enable mask, reserved bit held zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			interrupt_enable_mask <= csr_pkg::RST_INTEN;
		end else if (wr_en && idx == csr_pkg::IDX_INTEN) begin
			interrupt_enable_mask <= wdat & csr_pkg::IRQ_MASK;
		end
	end

	// request flags: write one to clear, a new event wins
	assign hw_set = (irq_event_i | ({7'h00, t16_event} << csr_pkg::IRQ_T16))
		& csr_pkg::IRQ_MASK;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			interrupt_request_flags <= csr_pkg::RST_INTRQ;
		end else begin
			if (wr_en && idx == csr_pkg::IDX_INTRQ) begin
				interrupt_request_flags <= (interrupt_request_flags & ~wdat) | hw_set;
			end else begin
				interrupt_request_flags <= interrupt_request_flags | hw_set;
			end
		end
	end

	assign irq_o = |(interrupt_request_flags & interrupt_enable_mask);

	// clock outputs, decoded straight from stored bits
	assign ck_dec = clk_decode(clock_mode_control[csr_pkg::CK_TYPE],
		clock_mode_control[csr_pkg::CK_SEL_HI:csr_pkg::CK_SEL_LO]);
	assign sys_clk_rsvd_o = ck_dec[9];
	assign sys_clk_src_o  = ck_dec[8:7];
	assign sys_clk_div_o  = ck_dec[6:0];
	assign fast_osc_en_o  = clock_mode_control[csr_pkg::CK_FAST_EN];
	assign slow_osc_en_o  = clock_mode_control[csr_pkg::CK_SLOW_EN];
	assign watchdog_en_o  = clock_mode_control[csr_pkg::CK_WDT_EN]
		& clock_mode_control[csr_pkg::CK_SLOW_EN];
	assign external_reset_input_en_o = clock_mode_control[csr_pkg::CK_RST_PIN];
	assign stack_pointer_o = stack_pointer;

	// two-stage sync of oscillators and pins, plus edge copy
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_a <= 5'h00;
			sync_b <= 5'h00;
			sync_c <= 5'h00;
		end else begin
			sync_a <= {port_a_pin_zero_i, port_a_pin_four_i,
				external_crystal_oscillator_i, slow_internal_oscillator_i,
				fast_internal_oscillator_i};
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end
	// oscillators faster than half of clk_i alias; a limitation
	assign fast_rise = sync_b[0] & ~sync_c[0];
	assign slow_rise = sync_b[1] & ~sync_c[1];
	assign ext_rise  = sync_b[2] & ~sync_c[2];
	assign pa4_fall  = ~sync_b[3] & sync_c[3];
	assign pa0_fall  = ~sync_b[4] & sync_c[4];

	// timer clock source select
	always_comb begin
		src_tick = 1'b0;
		case (wide_timer_mode[7:5])
			csr_pkg::T16_SYS:  src_tick = 1'b1;
			csr_pkg::T16_PA4:  src_tick = pa4_fall;
			csr_pkg::T16_FAST: src_tick = fast_rise;
			csr_pkg::T16_EXT:  src_tick = ext_rise;
			csr_pkg::T16_SLOW: src_tick = slow_rise;
			csr_pkg::T16_PA0:  src_tick = pa0_fall;
			default:           src_tick = 1'b0;
		endcase
	end

	// prescaler mask from field 4:3
	always_comb begin
		pre_mask = csr_pkg::PRE_M1;
		// divide by 1, 4, 16, 64
		case (wide_timer_mode[4:3])
			2'h0:    pre_mask = csr_pkg::PRE_M1;
			2'h1:    pre_mask = csr_pkg::PRE_M4;
			2'h2:    pre_mask = csr_pkg::PRE_M16;
			default: pre_mask = csr_pkg::PRE_M64;
		endcase
	end
	assign div_tick   = src_tick & ((prescale & pre_mask) == pre_mask);
	assign next_count = timer_count + 16'h0001;
	assign bit_sel    = 4'(csr_pkg::T16_BIT_BASE) + {1'b0, wide_timer_mode[2:0]};
	// chosen bit toggles on this increment
	assign t16_event  = div_tick & (next_count[bit_sel] != timer_count[bit_sel]);

	// prescaler runs on source ticks only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prescale <= 6'h00;
		end else if (src_tick) begin
			prescale <= prescale + 6'h01;
		end
	end

	// counter holds while the timer is disabled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_count <= 16'h0000;
		end else if (div_tick) begin
			timer_count <= next_count;
		end
	end
	assign timer_count_o = timer_count;

	// checks
	chk_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
	chk_flag_upper_ones: assert property (@(posedge clk_i) disable iff (rst_i)
		(bus_req && !wb_ack_o && !wb_we_i && aligned && idx == csr_pkg::IDX_FLAG)
		|=> wb_dat_o[7:4] == 4'hF) else $error("flag upper bits not one");
	chk_flag_alu_wins: assert property (@(posedge clk_i) disable iff (rst_i)
		alu_flag_upd_i[csr_pkg::FLAG_OV]
		|=> flag_low[csr_pkg::FLAG_OV] == $past(alu_flag_val_i[csr_pkg::FLAG_OV]))
		else $error("overflow flag missed update");
	chk_flag_zero_upd: assert property (@(posedge clk_i) disable iff (rst_i)
		alu_flag_upd_i[csr_pkg::FLAG_Z]
		|=> flag_low[csr_pkg::FLAG_Z] == $past(alu_flag_val_i[csr_pkg::FLAG_Z]))
		else $error("zero flag missed update");
	chk_sp_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_en && idx == csr_pkg::IDX_SP) |=> stack_pointer_o == $past(wb_dat_i[7:0]))
		else $error("stack pointer write lost");
	chk_wdt_gated: assert property (@(posedge clk_i) disable iff (rst_i)
		!clock_mode_control[csr_pkg::CK_SLOW_EN] |-> !watchdog_en_o)
		else $error("watchdog on with slow osc off");
	chk_req_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		(irq_event_i[0]) |=> interrupt_request_flags[0][*2])
		else $error("request bit not sticky");
	chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_o == |(interrupt_request_flags & interrupt_enable_mask))
		else $error("irq level mismatch");
	chk_timer_off: assert property (@(posedge clk_i) disable iff (rst_i)
		(wide_timer_mode[7:5] == csr_pkg::T16_OFF) |=> $stable(timer_count))
		else $error("timer moved while disabled");
	chk_timer_event: assert property (@(posedge clk_i) disable iff (rst_i)
		t16_event |=> interrupt_request_flags[csr_pkg::IRQ_T16])
		else $error("timer event lost");
	chk_timer_step: assert property (@(posedge clk_i) disable iff (rst_i)
		div_tick |=> timer_count == $past(timer_count) + 16'h0001)
		else $error("timer step wrong");
	cov_bus_write: cover property (@(posedge clk_i) disable iff (rst_i)
		wr_en && idx == csr_pkg::IDX_CLKMD);
	cov_req_clear: cover property (@(posedge clk_i) disable iff (rst_i)
		wr_en && idx == csr_pkg::IDX_INTRQ && interrupt_request_flags != 8'h00);
	cov_irq_raised: cover property (@(posedge clk_i) disable iff (rst_i)
		$rose(irq_o));
	cov_timer_event: cover property (@(posedge clk_i) disable iff (rst_i)
		t16_event);

endmodule // csr_bank
`default_nettype wire

/* File: design/csr_pkg.sv */
// constants for the core system register bank
package csr_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_FLAG  = 6'h00;
	localparam logic [5:0] IDX_SP    = 6'h02;
	localparam logic [5:0] IDX_CLKMD = 6'h03;
	localparam logic [5:0] IDX_INTEN = 6'h04;
	localparam logic [5:0] IDX_INTRQ = 6'h05;
	localparam logic [5:0] IDX_WIDE_TIMER_MODE  = 6'h06;
	// reset values
	localparam logic [7:0] RST_FLAG  = 8'h00;
	localparam logic [7:0] RST_SP    = 8'h00;
	localparam logic [7:0] RST_CLKMD = 8'hF6;
	localparam logic [7:0] RST_INTEN = 8'h00;
	localparam logic [7:0] RST_INTRQ = 8'h00;
	localparam logic [7:0] RST_WIDE_TIMER_MODE  = 8'h00;
	// status flag layout
	localparam logic [3:0] FLAG_ONES   = 4'hF;
	localparam int         FLAG_OV     = 3;
	localparam int         FLAG_AC     = 2;
	localparam int         FLAG_C      = 1;
	localparam int         FLAG_Z      = 0;
	// clock mode layout
	localparam int         CK_SEL_HI   = 7;
	localparam int         CK_SEL_LO   = 5;
	localparam int         CK_FAST_EN  = 4;
	localparam int         CK_TYPE     = 3;
	localparam int         CK_SLOW_EN  = 2;
	localparam int         CK_WDT_EN   = 1;
	localparam int         CK_RST_PIN  = 0;
	// system clock sources
	localparam logic [1:0] SRC_FAST    = 2'h0;
	localparam logic [1:0] SRC_SLOW    = 2'h1;
	localparam logic [1:0] SRC_EXT     = 2'h2;
	// interrupt map; bit 3 is reserved
	localparam logic [7:0] IRQ_MASK    = 8'hF7;
	localparam int         IRQ_T16     = 2;
	// timer mode layout and clock codes
	localparam logic [2:0] T16_OFF     = 3'h0;
	localparam logic [2:0] T16_SYS     = 3'h1;
	localparam logic [2:0] T16_PA4     = 3'h3;
	localparam logic [2:0] T16_FAST    = 3'h4;
	localparam logic [2:0] T16_EXT     = 3'h5;
	localparam logic [2:0] T16_SLOW    = 3'h6;
	localparam logic [2:0] T16_PA0     = 3'h7;
	localparam int         T16_BIT_BASE = 8;
	// prescaler masks for /1 /4 /16 /64
	localparam logic [5:0] PRE_M1      = 6'h00;
	localparam logic [5:0] PRE_M4      = 6'h03;
	localparam logic [5:0] PRE_M16     = 6'h0F;
	localparam logic [5:0] PRE_M64     = 6'h3F;
endpackage

/* File: tb/csr_osc_model.sv */
// oscillator model feeding the timer clock inputs of the bank
`timescale 1ns/1ps
`default_nettype none
module csr_osc_model (
	input  wire logic clk_i,     // system clock
	input  wire logic rst_i,     // synchronous reset
	input  wire logic fast_en_i, // fast oscillator enable
	input  wire logic slow_en_i, // slow oscillator enable
	output logic      fast_o,    // fast level, period 8 clocks
	output logic      slow_o,    // slow level, period 32 clocks
	output logic      ext_o      // crystal level, period 16 clocks
);
	logic [4:0] phase; // free running phase counter

	// phase counter; rates stay well below clk/4 for the synchronisers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase <= 5'h00;
		end else begin
			phase <= phase + 5'h01;
		end
	end

	// stopped oscillators
	// a disabled oscillator sits low, so no stray edges reach the timer
	assign fast_o = fast_en_i & phase[2];
	assign slow_o = slow_en_i & phase[4];
	// crystal has no enable in this bank, it always runs
	assign ext_o  = phase[3];
endmodule // csr_osc_model
`default_nettype wire

/* File: tb/test_core_system_registers.sv */
// self-checking bench for the core system register bank
`timescale 1ns/1ps
`default_nettype none
module test_core_system_registers;
	logic        clk_i, rst_i;          // clock, reset
	logic        cyc, stb, we;          // bus request
	logic [7:0]  adr;                   // byte address
	logic [3:0]  sel;                   // byte enables
	logic [31:0] wdat, rdat;            // bus data
	logic        ack;                   // bus answer
	logic [3:0]  upd, fval;             // alu flag strobes, values
	logic [7:0]  ev, sp;                // event pulses, stack pointer
	logic        fosc, sosc, xosc;      // oscillator levels
	logic        pa4, pa0;              // counted pins
	logic [1:0]  src;                   // clock source
	logic [6:0]  div;                   // clock divider
	logic        rsvd, fen, sen, wen, ren, irq;
	logic [15:0] cnt, c0;               // timer count, snapshot
	logic [7:0]  q;                     // last read byte
	int          n_mismatch = 0;
	int          samples_checked = 0;
	// {reserved, source, divider} per {type, code}
	localparam logic [9:0] ckt [16] = '{10'h004, 10'h002, 10'h200, 10'h104, 10'h102,
		10'h101, 10'h084, 10'h081, 10'h010, 10'h008, 10'h090, 10'h020, 10'h040,
		10'h108, 10'h200, 10'h200};
	localparam logic [7:0]  ra [6] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
	localparam logic [7:0]  rv [6] = '{8'hF0, 8'h00, 8'hF6, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0]  ce [3] = '{8'hE2, 8'hE7, 8'hF4};
	localparam logic [3:0]  cx [3] = '{4'h0, 4'h7, 4'hC};
	// timer modes and counts expected over 192 clocks
	localparam logic [7:0]  tm [9] = '{8'h00, 8'h40, 8'h20, 8'h28, 8'h30, 8'h38,
		8'h80, 8'hA0, 8'hC0};
	localparam logic [15:0] td [9] = '{16'h0000, 16'h0000, 16'h00C0, 16'h0030,
		16'h000C, 16'h0003, 16'h0018, 16'h000C, 16'h0006};

	csr_bank dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .alu_flag_upd_i(upd), .alu_flag_val_i(fval), .irq_event_i(ev),
		.fast_internal_oscillator_i(fosc), .slow_internal_oscillator_i(sosc),
		.external_crystal_oscillator_i(xosc), .port_a_pin_four_i(pa4),
		.port_a_pin_zero_i(pa0), .stack_pointer_o(sp), .sys_clk_src_o(src),
		.sys_clk_div_o(div), .sys_clk_rsvd_o(rsvd), .fast_osc_en_o(fen),
		.slow_osc_en_o(sen), .watchdog_en_o(wen), .external_reset_input_en_o(ren),
		.timer_count_o(cnt), .irq_o(irq));

	csr_osc_model osc_u (.clk_i(clk_i), .rst_i(rst_i), .fast_en_i(fen),
		.slow_en_i(sen), .fast_o(fosc), .slow_o(sosc), .ext_o(xosc));

	// free running 100 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// verdict and end of run
	task automatic test_done;
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// one counted comparison
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask

	// classic cycle held until ack is sampled, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= {24'h000000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat[7:0];
		chk("bus_ack", 16'h0001, {15'h0000, ack});
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, a, d, 4'hF);
	endtask

	task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00, 4'hF);
		chk(nm, {8'h00, e}, {8'h00, q});
	endtask

	// one-cycle event pulse, then let the request settle
	task automatic pulse(input logic [7:0] v);
		ev <= v;
		@(posedge clk_i);
		ev <= 8'h00;
		@(posedge clk_i);
	endtask

	// alu flag update for one cycle
	task automatic alu(input logic [3:0] u, input logic [3:0] v);
		upd <= u;
		fval <= v;
		@(posedge clk_i);
		upd <= 4'h0;
	endtask

	// bounded wait for a low count pattern
	task automatic wait_cnt(input logic [9:0] v);
		int n;
		n = 0;
		while (cnt[9:0] !== v && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
	endtask

	// hang guard, well beyond the expected run
	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		test_done;
	end

	// main sequence
	initial begin
		rst_i = 1'b1;
		{cyc, stb, we, adr, sel, wdat} = '0;
		{upd, fval, ev} = '0;
		pa4 = 1'b1;
		pa0 = 1'b1;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int i = 0; i < 6; i++) rd("reset_value", ra[i], rv[i]);
		// status flags
		wr(8'h00, 8'h00);
		rd("flag_ones", 8'h00, 8'hF0);
		wr(8'h00, 8'h0A);
		rd("flag_sw", 8'h00, 8'hFA);
		alu(4'hF, 4'h5);
		rd("flag_alu", 8'h00, 8'hF5);
		alu(4'h9, 4'h0);
		rd("flag_part", 8'h00, 8'hF4);
		// stack pointer write, then a write with no byte enables is dropped
		wr(8'h08, 8'h3C);
		wb(1'b1, 8'h08, 8'h10, 4'h0);
		rd("sp_read", 8'h08, 8'h3C);
		chk("sp_out", 16'h003C, {8'h00, sp});
		rd("unmapped", 8'h04, 8'h00);
		// every clock code of both types
		for (int i = 0; i < 16; i++) begin
			wr(8'h0C, {i[2:0], 1'b1, i[3], 3'b110});
			chk("clk_rsvd", {15'h0000, ckt[i][9]}, {15'h0000, rsvd});
			if (ckt[i][9] !== 1'b1) chk("clk_sel", {7'h00, ckt[i][8:0]}, {7'h00, src, div});
		end
		for (int i = 0; i < 3; i++) begin
			wr(8'h0C, ce[i]);
			rd("clkmd_rw", 8'h0C, ce[i]);
			chk("osc_en", {12'h000, cx[i]}, {12'h000, fen, sen, wen, ren});
		end
		wr(8'h0C, 8'hF6);
		// requests sticky, write of zero leaves them
		pulse(8'hFF);
		wr(8'h14, 8'h00);
		rd("intrq_hold", 8'h14, 8'hF7);
		wr(8'h10, 8'hFF);
		rd("inten_rw", 8'h10, 8'hF7);
		wr(8'h14, 8'hF7);
		rd("intrq_clr", 8'h14, 8'h00);
		// each source against its own and a foreign enable
		for (int b = 0; b < 8; b++) begin
			if (b != 3) begin
				pulse(8'h01 << b);
				wr(8'h10, 8'h01 << ((b + 1) % 8));
				chk("irq_other", 16'h0000, {15'h0000, irq});
				wr(8'h10, 8'h01 << b);
				chk("irq_own", 16'h0001, {15'h0000, irq});
				wr(8'h14, 8'h01 << b);
				chk("irq_clr", 16'h0000, {15'h0000, irq});
			end
		end
		// timer sources and prescaler over a fixed window
		for (int i = 0; i < 9; i++) begin
			wr(8'h18, tm[i]);
			repeat (8) @(posedge clk_i);
			c0 = cnt;
			repeat (192) @(posedge clk_i);
			chk("timer_delta", td[i], cnt - c0);
		end
		// fast source stopped gives no ticks
		wr(8'h0C, 8'hE6);
		wr(8'h18, 8'h80);
		repeat (8) @(posedge clk_i);
		c0 = cnt;
		repeat (64) @(posedge clk_i);
		chk("timer_fast_off", 16'h0000, cnt - c0);
		wr(8'h0C, 8'hF6);
		// pin four gets five falls, pin zero three
		for (int i = 0; i < 2; i++) begin
			wr(8'h18, i[0] ? 8'hE0 : 8'h60);
			repeat (8) @(posedge clk_i);
			c0 = cnt;
			for (int k = 0; k < 5; k++) begin
				pa4 <= 1'b0;
				pa0 <= (k < 3) ? 1'b0 : 1'b1;
				repeat (4) @(posedge clk_i);
				pa4 <= 1'b1;
				pa0 <= 1'b1;
				repeat (4) @(posedge clk_i);
			end
			repeat (8) @(posedge clk_i);
			chk("timer_pin", i[0] ? 16'h0003 : 16'h0005, cnt - c0);
		end
		// event only when the chosen bit 9 toggles
		wr(8'h18, 8'h21);
		wr(8'h10, 8'h04);
		wait_cnt(10'h2F0);
		wr(8'h14, 8'h04);
		wait_cnt(10'h310);
		rd("t16_bit8", 8'h14, 8'h00);
		chk("irq_t16_early", 16'h0000, {15'h0000, irq});
		wait_cnt(10'h010);
		rd("t16_bit9", 8'h14, 8'h04);
		chk("irq_t16", 16'h0001, {15'h0000, irq});
		test_done;
	end
endmodule // test_core_system_registers
`default_nettype wire
